/* logic/ipr_core.sv */
// ipr_core: internal-parameter conversion sequencer with digital redundancy check
`timescale 1ns/1ns
`default_nettype none
module ipr_core
  import ipr_pkg::*;
#(
  // ns per table microsecond; shrink to shorten every conversion in simulation
  parameter int unsigned US_NS = NS_PER_US
) (
  // clock, reset, enable
  input  wire logic                core_clk_in,
  input  wire logic                rstn_in,
  input  wire logic                ce_in,
  // register port
  input  wire logic [3:0]          reg_addr_in,
  input  wire logic [15:0]         reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic [15:0]              reg_rdata_out,
  // modulator streams, one per converter
  input  wire logic [NUM_ADCS-1:0] mod_bit_in,
  input  wire logic                mod_valid_in,
  // status
  output logic                     busy_out,
  output logic                     done_out
);

  ipr_state_e          state;
  ipr_cmd_s            cmd;
  ipr_cfg_s            cfg;
  logic [CNT_W-1:0]    cyc_cnt;
  logic [2:0]          step;
  logic                fault_seen;
  logic [RES_W-1:0]    res [NUM_PARAMS];
  logic                start;
  logic                store;
  logic                finish;
  logic                win_clear;
  logic                apply;
  logic [1:0]          spare_idx;
  logic                spare_bit;
  logic [RES_W-1:0]    prim_res [NUM_ADCS];
  logic [RES_W-1:0]    spare_res;
  logic [RES_W-1:0]    store_code;
  logic                store_fault;
  logic [CNT_W-1:0]    mark_now;
  logic [CNT_W-1:0]    total_now;

  // cycle count of a sample end (k < 4) or of the command end (k == 4)
  function automatic logic [CNT_W-1:0] mark_cyc(input logic [2:0] m, input logic [2:0] k);
    int unsigned us;
    us = (k >= 3'(NUM_PARAMS)) ? TOTAL_US[m] : MARK_US[m][k[1:0]];
    return CNT_W'(ipr_us_to_cyc(us, US_NS));
  endfunction

  // converter that the spare machine shadows; internal values live on the first
  function automatic logic [1:0] path_of(input logic [1:0] ps);
    return (ps == 2'h0) ? 2'h0 : ps - 2'h1;
  endfunction

  assign mark_now  = mark_cyc(cmd.mode, step);
  assign total_now = mark_cyc(cmd.mode, 3'(NUM_PARAMS));
  assign start     = reg_wr_in && (reg_addr_in == REG_CMD) && (state == IPR_IDLE);
  assign store     = (state == IPR_RUN) && (step < 3'(NUM_PARAMS)) && (cyc_cnt == mark_now);
  // same end for plain and checked: the check adds no cycles
  assign finish    = (state == IPR_RUN) && (step == 3'(NUM_PARAMS))
                     && (cyc_cnt == total_now);
  assign win_clear = start || store;

  // checked only on the checked command, only where a path shadows the first converter
  assign apply     = cmd.checked && (path_of(cfg.path_sel) == 2'h0);
  assign spare_idx = path_of(cfg.path_sel);
  assign spare_bit = mod_bit_in[spare_idx];

  // three primary machines, one for each converter
  genvar g;
  generate
    for (g = 0; g < NUM_ADCS; g++) begin : g_adc
      ipr_decim #(.W(ACC_W)) u_decim (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .ce_in       (ce_in),
        .sample_in   (mod_valid_in && (state == IPR_RUN)),
        .bit_in      (mod_bit_in[g]),
        .clear_in    (win_clear),
        .result_out  (prim_res[g])
      );
    end
  endgenerate

  // the single spare machine
  ipr_decim #(.W(ACC_W)) u_spare (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .ce_in       (ce_in),
    .sample_in   (mod_valid_in && (state == IPR_RUN)),
    .bit_in      (spare_bit),
    .clear_in    (win_clear),
    .result_out  (spare_res)
  );

  ipr_compare u_cmp (
    .primary_in (prim_res[0]),
    .spare_in   (spare_res),
    .apply_in   (apply),
    .force_in   (cfg.force_fail),
    .code_out   (store_code),
    .fault_out  (store_fault)
  );

  // sequencer
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= IPR_IDLE;
    end else if (ce_in) begin
      case (state)
        IPR_IDLE: begin
          if (start) begin
            state <= IPR_RUN;
          end
        end
        IPR_RUN: begin
          if (finish) begin
            state <= IPR_IDLE;
          end
        end
        default: begin
          state <= IPR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cyc_cnt <= '0;
      step    <= '0;
    end else if (ce_in) begin
      if (start) begin
        cyc_cnt <= CNT_W'(1);
        step    <= '0;
      end else if (state == IPR_RUN) begin
        cyc_cnt <= cyc_cnt + CNT_W'(1);
        if (store) begin
          step <= step + 3'h1;
        end
      end
    end
  end

  // command latched at start; cannot change mid-conversion
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd <= '0;
    end else if (ce_in && start) begin
      cmd.mode    <= reg_wdata_in[CMD_MODE_LSB +: 3];
      cmd.checked <= reg_wdata_in[CMD_CHECK_BIT];
    end
  end

  // configuration is written any time; a new path feeds the spare machine from the next cycle, inside the current window
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg <= '{force_fail: 1'b0, path_sel: PS_RST};
    end else if (ce_in && reg_wr_in && (reg_addr_in == REG_CFG)) begin
      cfg.path_sel   <= reg_wdata_in[CFG_PS_LSB +: 2];
      cfg.force_fail <= reg_wdata_in[CFG_FORCE_BIT];
    end
  end

  // order of results: stack sum, die temperature, analog, digital supply
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NUM_PARAMS; i++) begin
        res[i] <= RESULT_RST;
      end
    end else if (ce_in && store) begin
      res[step[1:0]] <= store_code;
    end
  end

  // sticky fault seen; a fault store wins over the clear at start
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fault_seen <= 1'b0;
    end else if (ce_in) begin
      if (store && store_fault) begin
        fault_seen <= 1'b1;
      end else if (start) begin
        fault_seen <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= finish;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (ce_in) begin
      reg_rdata_out <= 16'h0000;
      if (reg_rd_in) begin
        case (reg_addr_in)
          REG_CMD:    reg_rdata_out <= {12'h000, cmd.checked, cmd.mode};
          REG_CFG:    reg_rdata_out <= {13'h0000, cfg.force_fail, cfg.path_sel};
          REG_STATUS: reg_rdata_out <= {11'h000, fault_seen, step, state == IPR_RUN};
          REG_SC:     reg_rdata_out <= res[0];
          REG_DIE_TEMP_RESULT:   reg_rdata_out <= res[1];
          REG_VA:     reg_rdata_out <= res[2];
          REG_VD:     reg_rdata_out <= res[3];
          default:    reg_rdata_out <= 16'h0000;
        endcase
      end
    end
  end

  assign busy_out = (state == IPR_RUN);

  // helper: stores since start and cycles since start
  logic [2:0]       chk_stores;
  logic [CNT_W-1:0] chk_cycles;
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chk_stores <= '0;
      chk_cycles <= '0;
    end else if (ce_in) begin
      if (start) begin
        chk_stores <= '0;
        chk_cycles <= CNT_W'(1);
      end else begin
        chk_cycles <= chk_cycles + CNT_W'(1);
        if (store) begin
          chk_stores <= chk_stores + 3'h1;
        end
      end
    end
  end

  AST_FOUR_RESULTS: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (ce_in && finish) |-> (chk_stores == 3'(NUM_PARAMS)))
    else $error("command ended without four stored results");

  AST_TOTAL_TIME: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (ce_in && finish) |-> (chk_cycles == mark_cyc(cmd.mode, 3'(NUM_PARAMS))))
    else $error("command length differs from the mode total");

  AST_SAME_TIME_CHECKED: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (ce_in && store) |-> (chk_cycles == mark_cyc(cmd.mode, step)))
    else $error("sample end moved away from its mark");

  AST_VALID_RANGE: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (ce_in && store && !store_fault) |=> (res[$past(step[1:0])] <= VALID_MAX))
    else $error("valid result above range top");

  AST_FAULT_NONZERO: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (ce_in && store && store_fault) |=> ((res[$past(step[1:0])] & 16'hfff0) == FAULT_HI
      && res[$past(step[1:0])][3:0] != 4'h0))
    else $error("fault code malformed or zero nibble");

  AST_PLAIN_NO_CHECK: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (store && !cmd.checked) |-> !store_fault)
    else $error("plain command produced a fault code");

  AST_FORCE_FAIL: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (store && cmd.checked && cfg.force_fail && cfg.path_sel <= 2'h1) |-> store_fault)
    else $error("forced fail did not replace the result");

  AST_NIBBLE_FLAG: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (store && apply && (prim_res[0][15:12] != spare_res[15:12])) |-> store_code[3])
    else $error("top nibble mismatch not flagged in bit 3");

  AST_PATH_SELECT: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cfg.path_sel != 2'h0) |-> (spare_bit == mod_bit_in[cfg.path_sel - 2'h1]))
    else $error("spare machine fed from the wrong converter");

  AST_BUSY_HOLD: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (ce_in && start) |=> busy_out && !done_out)
    else $error("start did not raise busy");

endmodule
`default_nettype wire

/* logic/ipr_pkg.sv */
// ipr_pkg: shared constants and carriers for the internal-parameter conversion block
package ipr_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned NS_PER_US     = 1000;

  // conversion geometry
  localparam int unsigned NUM_MODES  = 8;
  localparam int unsigned NUM_PARAMS = 4;
  localparam int unsigned NUM_ADCS   = 3;
  localparam int unsigned RES_W      = 16;
  localparam int unsigned CNT_W      = 26;
  localparam int unsigned ACC_W      = 26;

  // per-mode end of each sample, in us (27k,14k,7k,3k,2k,1k,422,26 Hz)
  localparam int unsigned MARK_US [NUM_MODES][NUM_PARAMS] = '{
    '{58, 104, 151, 198},
    '{87, 163, 238, 314},
    '{145, 279, 413, 547},
    '{261, 512, 762, 1012},
    '{494, 977, 1460, 1943},
    '{960, 1908, 2857, 3805},
    '{1890, 3770, 5649, 7529},
    '{29818, 59624, 89431, 119238}
  };
  // per-mode total command time, in us
  localparam int unsigned TOTAL_US [NUM_MODES] = '{
    742, 858, 1556, 2022, 2953, 4814, 8538, 134211
  };

  // register indices on the plain register port
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_CFG    = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_SC     = 4'h3;
  localparam logic [3:0] REG_DIE_TEMP_RESULT   = 4'h4;
  localparam logic [3:0] REG_VA     = 4'h5;
  localparam logic [3:0] REG_VD     = 4'h6;

  // field positions
  localparam int unsigned CMD_MODE_LSB  = 0;
  localparam int unsigned CMD_CHECK_BIT = 3;
  localparam int unsigned CFG_PS_LSB    = 0;
  localparam int unsigned CFG_FORCE_BIT = 2;

  // reset values and codes
  localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [RES_W-1:0] VALID_MAX  = 16'hdfff;
  localparam logic [RES_W-1:0] FAULT_HI   = 16'hff00;
  localparam logic [1:0]       PS_RST     = 2'h0;

  typedef struct packed {
    logic       checked;
    logic [2:0] mode;
  } ipr_cmd_s;

  typedef struct packed {
    logic       force_fail;
    logic [1:0] path_sel;
  } ipr_cfg_s;

  typedef enum logic [0:0] {
    IPR_IDLE,
    IPR_RUN
  } ipr_state_e;

  // least time in cycles: round up, never below one
  function automatic int unsigned ipr_us_to_cyc(input int unsigned us,
                                                input int unsigned ns_per_us);
    int unsigned c;
    c = (us * ns_per_us + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction

endpackage

/* logic/ipr_decim.sv */
// ipr_decim: one integration and differentiation machine for a modulator stream
`timescale 1ns/1ns
`default_nettype none
module ipr_decim
  import ipr_pkg::*;
#(
  parameter int unsigned W = ACC_W
) (
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rstn_in,
  input  wire logic             ce_in,
  // modulator stream
  input  wire logic             sample_in,
  input  wire logic             bit_in,
  input  wire logic             clear_in,
  // result of the current window
  output logic [RES_W-1:0]      result_out
);

  logic [W-1:0] acc;
  logic [W-1:0] base;
  logic [W-1:0] next_acc;
  logic [W-1:0] diff;

  assign next_acc = acc + W'(sample_in & bit_in);
  assign diff     = acc - base;
  // saturate rather than wrap: a wrapped code would look valid
  assign result_out = (diff > W'(16'hffff)) ? 16'hffff : diff[RES_W-1:0];

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc <= '0;
    end else if (ce_in) begin
      acc <= next_acc;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      base <= '0;
    end else if (ce_in && clear_in) begin
      base <= next_acc;
    end
  end

endmodule
`default_nettype wire

/* logic/ipr_compare.sv */
// ipr_compare: bitwise result check against the spare machine, fault code build
`timescale 1ns/1ns
`default_nettype none
module ipr_compare
  import ipr_pkg::*;
(
  // results of both machines
  input  wire logic [RES_W-1:0] primary_in,
  input  wire logic [RES_W-1:0] spare_in,
  // control
  input  wire logic             apply_in,
  input  wire logic             force_in,
  // stored value
  output logic [RES_W-1:0]      code_out,
  output logic                  fault_out
);

  logic [3:0] nib_miss;
  logic [3:0] nib_flag;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_nib
      assign nib_miss[g] = |(primary_in[4*g+3:4*g] ^ spare_in[4*g+3:4*g]);
    end
  endgenerate

  // forced fail with clean stream flags every nibble, never all zeros
  assign nib_flag  = (nib_miss != 4'h0) ? nib_miss : 4'hf;
  assign fault_out = apply_in && (force_in || (nib_miss != 4'h0));
  always_comb begin
    if (fault_out) begin
      code_out = FAULT_HI | {12'h000, nib_flag};
    end else if (primary_in > VALID_MAX) begin
      code_out = VALID_MAX;
    end else begin
      code_out = primary_in;
    end
  end

endmodule
`default_nettype wire

/* test/ipr_mod_model.sv */
// ipr_mod_model: modulator stream source emitting counted bursts of ones
`timescale 1ns/1ns
`default_nettype none
module ipr_mod_model
  import ipr_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                rstn_in,
  // burst request
  input  wire logic                fire_in,
  input  wire logic [3:0]          len_in,
  input  wire logic                slow_in,
  // stream to all three converters
  output logic [NUM_ADCS-1:0]      mod_bit_out,
  output logic                     mod_valid_out
);
  logic [3:0] rem;
  logic       phase;
  logic       emit;

  // slow source qualifies only every other cycle
  assign emit = (rem != 4'h0) && (!slow_in || phase);

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rem           <= 4'h0;
      phase         <= 1'b0;
      mod_bit_out   <= 3'h5;
      mod_valid_out <= 1'b0;
    end else begin
      phase         <= ~phase;
      mod_valid_out <= emit;
      // idle bits keep toggling so a stale level never looks like data
      mod_bit_out   <= emit ? 3'h7 : ~mod_bit_out;
      if (fire_in) begin
        rem <= len_in;
      end else if (emit) begin
        rem <= rem - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// tb_top: self-checking bench for the internal-parameter conversion block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ipr_pkg::*;
  // shrunk time base keeps the slowest mode short
  localparam int unsigned US = 2;

  logic                core_clk_in = 1'b0;
  logic                rstn_in     = 1'b0;
  logic [3:0]          reg_addr    = 4'h0;
  logic [15:0]         reg_wdata   = 16'h0000;
  logic                reg_wr      = 1'b0;
  logic                reg_rd      = 1'b0;
  logic [15:0]         rdata;
  logic [NUM_ADCS-1:0] mod_bit;
  logic                mod_valid;
  logic                busy;
  logic                done;
  logic                fire        = 1'b0;
  logic [3:0]          len         = 4'h0;
  logic                slow        = 1'b0;
  int                  num_errors  = 0;
  int                  checked     = 0;
  int                  busy_cnt    = 0;
  int                  done_cnt    = 0;

  always #4 core_clk_in = ~core_clk_in;

  ipr_core #(.US_NS(US)) u_ipr_core (
    .core_clk_in   (core_clk_in),
    .rstn_in       (rstn_in),
    .ce_in         (1'b1),
    .reg_addr_in   (reg_addr),
    .reg_wdata_in  (reg_wdata),
    .reg_wr_in     (reg_wr),
    .reg_rd_in     (reg_rd),
    .reg_rdata_out (rdata),
    .mod_bit_in    (mod_bit),
    .mod_valid_in  (mod_valid),
    .busy_out      (busy),
    .done_out      (done)
  );

  ipr_mod_model u_ipr_mod_model (
    .core_clk_in   (core_clk_in),
    .rstn_in       (rstn_in),
    .fire_in       (fire),
    .len_in        (len),
    .slow_in       (slow),
    .mod_bit_out   (mod_bit),
    .mod_valid_out (mod_valid)
  );

  // pre-edge values are counted, so snapshots taken at an edge exclude it
  always @(posedge core_clk_in) begin
    busy_cnt <= busy_cnt + ((busy === 1'b1) ? 1 : 0);
    done_cnt <= done_cnt + ((done === 1'b1) ? 1 : 0);
  end

  function automatic int cyc(input int unsigned us);
    int c;
    c = (us * US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk_in);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk_in);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk_in);
    reg_rd   <= 1'b0;
    #1;
    v = rdata;
  endtask

  // one command; bursts of 3..6 ones land inside the four windows
  task automatic run(input int m, input logic c, input logic [15:0] fc);
    int          t;
    int          st;
    int          tot;
    int          b0;
    int          d0;
    logic [15:0] v;
    tot  = cyc(TOTAL_US[m]);
    slow <= (m != 0);
    wr(REG_CMD, {12'h000, c, 3'(m)});
    b0 = busy_cnt;
    d0 = done_cnt;
    t  = 0;
    for (int k = 0; k < 4; k++) begin
      st = (k == 0) ? 0 : cyc(MARK_US[m][k-1]);
      while (t < st + 1) begin
        @(posedge core_clk_in);
        t++;
      end
      fire <= 1'b1;
      len  <= 4'(k + 3);
      @(posedge core_clk_in);
      t++;
      fire <= 1'b0;
    end
    while (t < tot + 3) begin
      @(posedge core_clk_in);
      t++;
    end
    chk("busy cycles", 32'(tot), 32'(busy_cnt - b0));
    chk("done pulses", 32'd1, 32'(done_cnt - d0));
    for (int k = 0; k < 4; k++) begin
      rd(4'(REG_SC + k), v);
      // raw counts are what the host scales, so the code itself is compared
      chk("result", (fc == 16'h0000) ? 32'(k + 3) : {16'h0000, fc}, {16'h0000, v});
    end
  endtask

  task automatic t_reset;
    logic [15:0] v;
    for (int a = 1; a < 7; a++) begin
      rd(4'(a), v);
      chk("reset value", 32'd0, {16'h0000, v});
    end
    rd(4'h9, v);
    chk("unmapped read", 32'd0, {16'h0000, v});
  endtask

  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      run(m, 1'b0, 16'h0000);
    end
  endtask

  task automatic t_check;
    logic [15:0] v;
    wr(REG_CFG, 16'h0000);
    run(0, 1'b1, 16'h0000);
    wr(REG_CFG, 16'h0005);
    run(0, 1'b1, 16'hff0f);
    rd(REG_STATUS, v);
    chk("fault seen", 32'd1, {31'h0, v[4]});
    run(0, 1'b0, 16'h0000);
    wr(REG_CFG, 16'h0006);
    run(0, 1'b1, 16'h0000);
    wr(REG_CFG, 16'h0007);
    run(0, 1'b1, 16'h0000);
    wr(REG_CFG, 16'h0004);
    run(0, 1'b1, 16'hff0f);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_check();
    t_modes();
    results();
  end

  // whole run needs about 40300 cycles
  initial begin
    repeat (60000) @(posedge core_clk_in);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
